// File: design/sdsa_pkg.sv
// Constants, command type and helpers for the SDRAM spacing and card space attribute block.
// Assumes a 32-bit classic Wishbone register bus and one 10 MHz bus clock.
// Operation
// - Precharge-start wait field adds 0, 1, 2 or 3 cycles before precharge.
// - Non-bank-active: wait after write-with-autoprecharge before activating that bank.
// - Bank-active: wait between plain write and precharge of the same bank.
// - Reserved bit below the precharge-start wait field reads zero; write zero.
// - Refresh idle field gives 2, 3, 5 or 8 idle cycles.
// - After auto-refresh, wait idle count before activate, refresh or mode set.
// - After self-refresh release, wait idle count before activate, refresh or mode set.
// - One shared SDRAM timing setting serves both areas 2 and 3.
// - Upper address line high: attribute bit 21 picks memory or I/O card.
// - Upper address line low: attribute bit 20 picks memory or I/O card.
// - Space attribute bits act only for areas set to the card interface.
// - Card register bits 31..22 and 19..15 read zero; write zeros.
`default_nettype none
package sdsa_pkg;
  // SDRAM commands seen by the spacing logic
  typedef enum logic [2:0] {
    SDSA_CMD_ROW_ACTIVATE,
    SDSA_CMD_READ,
    SDSA_CMD_PLAIN_WRITE,
    SDSA_CMD_WRITE_AUTOPRE,
    SDSA_CMD_PRECHARGE,
    SDSA_CMD_AUTO_REFRESH,
    SDSA_CMD_MODE_SET,
    SDSA_CMD_SELF_EXIT
  } sdsa_cmd_e;

  // Register byte offsets
  localparam logic [7:0]  SDSA_ADR_SDRAM   = 8'h00;
  localparam logic [7:0]  SDSA_ADR_CARD5   = 8'h04;
  localparam logic [7:0]  SDSA_ADR_CARD6   = 8'h08;
  localparam logic [7:0]  SDSA_ADR_MODE    = 8'h0C;
  localparam logic [7:0]  SDSA_ADR_STATUS  = 8'h10;

  // Writable bits and reset values
  localparam logic [31:0] SDSA_SDRAM_WMASK = 32'h0000_6D9B;
  localparam logic [31:0] SDSA_SDRAM_RST   = 32'h0000_0500;
  localparam logic [31:0] SDSA_CARD_WMASK  = 32'h0030_7FCF;
  localparam logic [31:0] SDSA_CARD_RST    = 32'h0000_0500;
  localparam logic [31:0] SDSA_MODE_WMASK  = 32'h0000_0007;
  localparam logic [31:0] SDSA_MODE_RST    = 32'h0000_0000;

  // Field positions
  localparam int SDSA_PRE_WAIT_LSB  = 3;
  localparam int SDSA_RSV_BIT       = 2;
  localparam int SDSA_REF_IDLE_LSB  = 0;
  localparam int SDSA_SA_UPPER_BIT  = 21;
  localparam int SDSA_SA_LOWER_BIT  = 20;
  localparam int SDSA_MODE_BANK_ACT = 0;
  localparam int SDSA_MODE_CARD5    = 1;
  localparam int SDSA_MODE_CARD6    = 2;
  localparam int SDSA_STAT_REF_BUSY = 4;
  localparam int SDSA_STAT_PENDING  = 5;

  // Sizes and idle cycle figures
  localparam int         SDSA_BANKS     = 4;
  localparam logic [3:0] SDSA_REF_IDLE0 = 4'h2;
  localparam logic [3:0] SDSA_REF_IDLE1 = 4'h3;
  localparam logic [3:0] SDSA_REF_IDLE2 = 4'h5;
  localparam logic [3:0] SDSA_REF_IDLE3 = 4'h8;

  // Refresh idle code to cycle count
  function automatic logic [3:0] sdsa_ref_cycles(input logic [1:0] code);
    case (code)
      2'h0:    sdsa_ref_cycles = SDSA_REF_IDLE0;
      2'h1:    sdsa_ref_cycles = SDSA_REF_IDLE1;
      2'h2:    sdsa_ref_cycles = SDSA_REF_IDLE2;
      default: sdsa_ref_cycles = SDSA_REF_IDLE3;
    endcase
  endfunction
endpackage
`default_nettype wire

// File: design/sdsa_gap_if.sv
// Interface between the spacing controller and one gap counter.
// Assumes both ends share the bus clock.
`timescale 1ns/10ps
`default_nettype none
interface sdsa_gap_if;
  logic       load;
  logic [3:0] val;
  logic [3:0] remain;
  logic       busy;
  // Controller end
  modport ctl (output load, output val, input remain, input busy);
  // Counter end
  modport cnt (input load, input val, output remain, output busy);
endinterface
`default_nettype wire

// File: design/sdsa_gap_cnt.sv
// Down counter holding off commands for a loaded number of cycles.
// Assumes load is a one-cycle pulse on the command issue edge.
`timescale 1ns/10ps
`default_nettype none
module sdsa_gap_cnt (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Counter link
  sdsa_gap_if.cnt   gap
);
  import sdsa_pkg::*;

  logic [3:0] remain_ff;

  // Load on issue, then count down to zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      remain_ff <= 4'h0;
    end else if (gap.load) begin
      remain_ff <= gap.val;
    end else if (remain_ff != 4'h0) begin
      remain_ff <= remain_ff - 4'h1;
    end
  end

  // Busy while cycles remain
  assign gap.remain = remain_ff;
  assign gap.busy   = (remain_ff != 4'h0);
endmodule
`default_nettype wire

// File: design/sdsa_card_attr.sv
// Space attribute decode for a card area.
// Assumes the attribute bits and area type come from registers.
`timescale 1ns/10ps
`default_nettype none
module sdsa_card_attr (
  // Area settings
  input  wire logic sa_upper_i,
  input  wire logic sa_lower_i,
  input  wire logic is_card_i,
  // Access
  input  wire logic upper_address_line_i,
  // Decoded space
  output logic      io_space_o,
  output logic      mem_space_o
);
  logic sel_attr;

  // Upper line picks which attribute bit applies
  assign sel_attr    = upper_address_line_i ? sa_upper_i : sa_lower_i;
  // Non-card areas get neither space
  assign io_space_o  = is_card_i & sel_attr;
  assign mem_space_o = is_card_i & ~sel_attr;
endmodule
`default_nettype wire

// File: design/sdsa_top.sv
// SDRAM command spacing and card space attribute selection with Wishbone registers.
// Assumes the command sequencer holds a request until req_ack_o and drops it after.
`timescale 1ns/10ps
`default_nettype none
module sdsa_top (
  // Clock and reset
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  // Wishbone slave
  input  wire logic                wb_cyc_i,
  input  wire logic                wb_stb_i,
  input  wire logic                wb_we_i,
  input  wire logic [7:0]          wb_adr_i,
  input  wire logic [3:0]          wb_sel_i,
  input  wire logic [31:0]         wb_dat_i,
  output logic      [31:0]         wb_dat_o,
  output logic                     wb_ack_o,
  // SDRAM command request
  input  wire logic                req_valid_i,
  input  wire sdsa_pkg::sdsa_cmd_e req_cmd_i,
  input  wire logic [1:0]          req_bank_i,
  output logic                     req_ack_o,
  // SDRAM command issue
  output logic                     cmd_valid_o,
  output sdsa_pkg::sdsa_cmd_e      cmd_o,
  output logic      [1:0]          cmd_bank_o,
  // Card access
  input  wire logic                card_req_i,
  input  wire logic                card_area_sel_i,
  input  wire logic                upper_address_line_i,
  output logic                     card_valid_o,
  output logic                     card_io_space_o,
  output logic                     card_mem_space_o
);
  import sdsa_pkg::*;

  // Registers
  logic [31:0] sdram_area_wait_control_ff;
  logic [31:0] card_area5_wait_control_ff;
  logic [31:0] card_area6_wait_control_ff;
  logic [31:0] mode_control_ff;
  logic [31:0] wb_dat_ff;
  logic        wb_ack_ff;
  logic        req_ack_ff;
  logic        cmd_valid_ff;
  sdsa_cmd_e   cmd_ff;
  logic [1:0]  cmd_bank_ff;
  logic        card_valid_ff;
  logic        card_io_ff;
  logic        card_mem_ff;

  // Decoded and combinational signals
  logic        wb_req;
  logic        wb_wr;
  logic [31:0] wmask;
  logic [31:0] rd_data;
  logic [31:0] status_word;
  logic [1:0]  pre_wait_code;
  logic [1:0]  ref_idle_code;
  logic        bank_active_mode;
  logic [SDSA_BANKS-1:0] bank_busy;
  logic        ref_block;
  logic        bank_block;
  logic        issue;
  logic        is_ref_guarded;
  logic        is_bank_guarded;
  logic        wr_loads;
  logic        io5;
  logic        mem5;
  logic        io6;
  logic        mem6;

  // Counter links
  sdsa_gap_if bank_gap [SDSA_BANKS] ();
  sdsa_gap_if ref_gap ();

  // Wishbone request and byte lane mask
  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_ff;
  assign wb_wr  = wb_req & wb_we_i;
  assign wmask  = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

  // Shared timing fields for areas 2 and 3
  assign pre_wait_code    = sdram_area_wait_control_ff[SDSA_PRE_WAIT_LSB +: 2];
  assign ref_idle_code    = sdram_area_wait_control_ff[SDSA_REF_IDLE_LSB +: 2];
  assign bank_active_mode = mode_control_ff[SDSA_MODE_BANK_ACT];

  // SDRAM timing register, reserved bits never stored
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sdram_area_wait_control_ff <= SDSA_SDRAM_RST;
    end else if (wb_wr && (wb_adr_i[7:2] == SDSA_ADR_SDRAM[7:2])) begin
      sdram_area_wait_control_ff <= ((sdram_area_wait_control_ff & ~wmask) |
                                     (wb_dat_i & wmask)) & SDSA_SDRAM_WMASK;
    end
  end

  // Card area 5 register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      card_area5_wait_control_ff <= SDSA_CARD_RST;
    end else if (wb_wr && (wb_adr_i[7:2] == SDSA_ADR_CARD5[7:2])) begin
      card_area5_wait_control_ff <= ((card_area5_wait_control_ff & ~wmask) |
                                     (wb_dat_i & wmask)) & SDSA_CARD_WMASK;
    end
  end

  // Card area 6 register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      card_area6_wait_control_ff <= SDSA_CARD_RST;
    end else if (wb_wr && (wb_adr_i[7:2] == SDSA_ADR_CARD6[7:2])) begin
      card_area6_wait_control_ff <= ((card_area6_wait_control_ff & ~wmask) |
                                     (wb_dat_i & wmask)) & SDSA_CARD_WMASK;
    end
  end

  // Mode register: bank-active mode and card area types
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_control_ff <= SDSA_MODE_RST;
    end else if (wb_wr && (wb_adr_i[7:2] == SDSA_ADR_MODE[7:2])) begin
      mode_control_ff <= ((mode_control_ff & ~wmask) | (wb_dat_i & wmask)) & SDSA_MODE_WMASK;
    end
  end

  // Live status of the spacing logic
  always_comb begin
    status_word                     = 32'h0000_0000;
    status_word[SDSA_BANKS-1:0]     = bank_busy;
    status_word[SDSA_STAT_REF_BUSY] = ref_block | ref_gap.busy;
    status_word[SDSA_STAT_PENDING]  = req_valid_i & ~issue;
  end

  // Read multiplexer, unmapped reads return zero
  always_comb begin
    if (wb_adr_i[7:2] == SDSA_ADR_SDRAM[7:2]) begin
      rd_data = sdram_area_wait_control_ff;
    end else if (wb_adr_i[7:2] == SDSA_ADR_CARD5[7:2]) begin
      rd_data = card_area5_wait_control_ff;
    end else if (wb_adr_i[7:2] == SDSA_ADR_CARD6[7:2]) begin
      rd_data = card_area6_wait_control_ff;
    end else if (wb_adr_i[7:2] == SDSA_ADR_MODE[7:2]) begin
      rd_data = mode_control_ff;
    end else if (wb_adr_i[7:2] == SDSA_ADR_STATUS[7:2]) begin
      rd_data = status_word;
    end else begin
      rd_data = 32'h0000_0000;
    end
  end

  // One-cycle acknowledge with registered read data
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_ff <= 1'b0;
      wb_dat_ff <= 32'h0000_0000;
    end else begin
      wb_ack_ff <= wb_req;
      if (wb_req && !wb_we_i) begin
        wb_dat_ff <= rd_data;
      end
    end
  end

  // Commands held off by the refresh idle time
  assign is_ref_guarded = (req_cmd_i == SDSA_CMD_ROW_ACTIVATE) ||
                          (req_cmd_i == SDSA_CMD_AUTO_REFRESH) ||
                          (req_cmd_i == SDSA_CMD_MODE_SET);
  // Commands held off by the precharge-start wait
  assign is_bank_guarded = bank_active_mode ? (req_cmd_i == SDSA_CMD_PRECHARGE)
                                            : (req_cmd_i == SDSA_CMD_ROW_ACTIVATE);
  // Writes that start a precharge-start wait in the current mode
  assign wr_loads = bank_active_mode ? (req_cmd_i == SDSA_CMD_PLAIN_WRITE)
                                     : (req_cmd_i == SDSA_CMD_WRITE_AUTOPRE);

  assign ref_block  = ref_gap.busy & is_ref_guarded;
  assign bank_block = bank_busy[req_bank_i] & is_bank_guarded;
  // Issue once per request, never in the acknowledge cycle
  assign issue = req_valid_i & ~req_ack_ff & ~ref_block & ~bank_block;

  // Per-bank precharge-start counters
  for (genvar b = 0; b < SDSA_BANKS; b++) begin : g_bank
    assign bank_gap[b].load = issue & wr_loads & (req_bank_i == 2'(b));
    assign bank_gap[b].val  = {2'h0, pre_wait_code};
    assign bank_busy[b]     = bank_gap[b].busy;
    sdsa_gap_cnt u_bank_cnt (
      .clk_i (clk_i),
      .rst_i (rst_i),
      .gap   (bank_gap[b])
    );
  end

  // Refresh and self-refresh release idle counter
  assign ref_gap.load = issue && ((req_cmd_i == SDSA_CMD_AUTO_REFRESH) ||
                                  (req_cmd_i == SDSA_CMD_SELF_EXIT));
  assign ref_gap.val  = sdsa_ref_cycles(ref_idle_code);
  sdsa_gap_cnt u_ref_cnt (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .gap   (ref_gap)
  );

  // Command issue and request acknowledge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmd_valid_ff <= 1'b0;
      req_ack_ff   <= 1'b0;
      cmd_ff       <= SDSA_CMD_READ;
      cmd_bank_ff  <= 2'h0;
    end else begin
      cmd_valid_ff <= issue;
      req_ack_ff   <= issue;
      if (issue) begin
        cmd_ff      <= req_cmd_i;
        cmd_bank_ff <= req_bank_i;
      end
    end
  end

  // Space attribute decode per card area
  sdsa_card_attr u_attr5 (
    .sa_upper_i           (card_area5_wait_control_ff[SDSA_SA_UPPER_BIT]),
    .sa_lower_i           (card_area5_wait_control_ff[SDSA_SA_LOWER_BIT]),
    .is_card_i            (mode_control_ff[SDSA_MODE_CARD5]),
    .upper_address_line_i (upper_address_line_i),
    .io_space_o           (io5),
    .mem_space_o          (mem5)
  );
  sdsa_card_attr u_attr6 (
    .sa_upper_i           (card_area6_wait_control_ff[SDSA_SA_UPPER_BIT]),
    .sa_lower_i           (card_area6_wait_control_ff[SDSA_SA_LOWER_BIT]),
    .is_card_i            (mode_control_ff[SDSA_MODE_CARD6]),
    .upper_address_line_i (upper_address_line_i),
    .io_space_o           (io6),
    .mem_space_o          (mem6)
  );

  // Registered space selection for the access
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      card_valid_ff <= 1'b0;
      card_io_ff    <= 1'b0;
      card_mem_ff   <= 1'b0;
    end else begin
      card_valid_ff <= card_req_i;
      card_io_ff    <= card_req_i & (card_area_sel_i ? io6 : io5);
      card_mem_ff   <= card_req_i & (card_area_sel_i ? mem6 : mem5);
    end
  end

  // Outputs
  assign wb_dat_o         = wb_dat_ff;
  assign wb_ack_o         = wb_ack_ff;
  assign req_ack_o        = req_ack_ff;
  assign cmd_valid_o      = cmd_valid_ff;
  assign cmd_o            = cmd_ff;
  assign cmd_bank_o       = cmd_bank_ff;
  assign card_valid_o     = card_valid_ff;
  assign card_io_space_o  = card_io_ff;
  assign card_mem_space_o = card_mem_ff;

  // Checker helpers: idle cycles seen since the last spacing command
  logic [3:0] chk_ref_since_ff;
  logic [3:0] chk_ref_need_ff;
  logic [3:0] chk_bank_since_ff [SDSA_BANKS];
  logic [3:0] chk_bank_need_ff  [SDSA_BANKS];
  logic       chk_sel_upper;
  logic       chk_sel_lower;
  logic       chk_sel_card;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      chk_ref_since_ff <= 4'hF;
      chk_ref_need_ff  <= 4'h0;
    end else if (cmd_valid_o && ((cmd_o == SDSA_CMD_AUTO_REFRESH) ||
                                 (cmd_o == SDSA_CMD_SELF_EXIT))) begin
      chk_ref_since_ff <= 4'h0;
      chk_ref_need_ff  <= sdsa_ref_cycles(ref_idle_code);
    end else if (chk_ref_since_ff != 4'hF) begin
      chk_ref_since_ff <= chk_ref_since_ff + 4'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    for (int b = 0; b < SDSA_BANKS; b++) begin
      if (rst_i) begin
        chk_bank_since_ff[b] <= 4'hF;
        chk_bank_need_ff[b]  <= 4'h0;
      end else if (cmd_valid_o && (cmd_bank_o == b[1:0]) &&
                   ((cmd_o == SDSA_CMD_WRITE_AUTOPRE) || (cmd_o == SDSA_CMD_PLAIN_WRITE))) begin
        chk_bank_since_ff[b] <= 4'h0;
        chk_bank_need_ff[b]  <= {2'h0, pre_wait_code};
      end else if (chk_bank_since_ff[b] != 4'hF) begin
        chk_bank_since_ff[b] <= chk_bank_since_ff[b] + 4'h1;
      end
    end
  end

  assign chk_sel_upper = card_area_sel_i ? card_area6_wait_control_ff[SDSA_SA_UPPER_BIT]
                                         : card_area5_wait_control_ff[SDSA_SA_UPPER_BIT];
  assign chk_sel_lower = card_area_sel_i ? card_area6_wait_control_ff[SDSA_SA_LOWER_BIT]
                                         : card_area5_wait_control_ff[SDSA_SA_LOWER_BIT];
  assign chk_sel_card  = card_area_sel_i ? mode_control_ff[SDSA_MODE_CARD6]
                                         : mode_control_ff[SDSA_MODE_CARD5];

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Activate or precharge keeps the precharge-start wait of its bank
  property p_pre_start_gap;
    cmd_valid_o && ((cmd_o == SDSA_CMD_ROW_ACTIVATE) || (cmd_o == SDSA_CMD_PRECHARGE)) &&
    (chk_bank_need_ff[cmd_bank_o] != 4'h0) |->
      (chk_bank_since_ff[cmd_bank_o] >= chk_bank_need_ff[cmd_bank_o]);
  endproperty
  a_pre_start_gap: assert property (p_pre_start_gap)
    else $error("precharge-start wait cut short");

  // Write with autoprecharge in non-bank-active mode blocks its bank
  property p_wra_blocks_bank;
    cmd_valid_o && (cmd_o == SDSA_CMD_WRITE_AUTOPRE) && !bank_active_mode &&
    (pre_wait_code == 2'h3) |-> bank_busy[cmd_bank_o] ##1 bank_busy[$past(cmd_bank_o)];
  endproperty
  a_wra_blocks_bank: assert property (p_wra_blocks_bank)
    else $error("bank not held after write with autoprecharge");

  // Bank-active mode: no precharge right after a plain write when waiting 3
  property p_write_to_pre;
    cmd_valid_o && (cmd_o == SDSA_CMD_PLAIN_WRITE) && bank_active_mode &&
    (pre_wait_code == 2'h3) |->
      ##1 (!(cmd_valid_o && (cmd_o == SDSA_CMD_PRECHARGE)))[*3];
  endproperty
  a_write_to_pre: assert property (p_write_to_pre)
    else $error("precharge too soon after plain write");

  // Guarded commands keep the refresh idle count
  property p_ref_gap;
    cmd_valid_o && ((cmd_o == SDSA_CMD_ROW_ACTIVATE) || (cmd_o == SDSA_CMD_AUTO_REFRESH) ||
                    (cmd_o == SDSA_CMD_MODE_SET)) |-> (chk_ref_since_ff >= chk_ref_need_ff);
  endproperty
  a_ref_gap: assert property (p_ref_gap)
    else $error("refresh idle count violated");

  // Longest idle code holds eight clear cycles after refresh
  property p_ref_eight;
    cmd_valid_o && (cmd_o == SDSA_CMD_AUTO_REFRESH) && (ref_idle_code == 2'h3) |->
      ##1 (!(cmd_valid_o && (cmd_o == SDSA_CMD_ROW_ACTIVATE)))[*8];
  endproperty
  a_ref_eight: assert property (p_ref_eight)
    else $error("activate inside eight-cycle refresh idle");

  // Self-refresh release holds at least two idle cycles
  property p_self_exit_gap;
    cmd_valid_o && (cmd_o == SDSA_CMD_SELF_EXIT) |->
      ##1 (!(cmd_valid_o && (cmd_o == SDSA_CMD_MODE_SET)))[*2];
  endproperty
  a_self_exit_gap: assert property (p_self_exit_gap)
    else $error("mode set too soon after self-refresh release");

  // Issue pulses once, with its acknowledge
  property p_issue_pulse;
    cmd_valid_o |-> req_ack_o ##1 !cmd_valid_o;
  endproperty
  a_issue_pulse: assert property (p_issue_pulse)
    else $error("command issue not a single acknowledged pulse");

  // Upper half uses the upper attribute bit
  property p_card_upper;
    card_req_i && upper_address_line_i && chk_sel_card |=>
      (card_io_space_o == $past(chk_sel_upper)) && (card_mem_space_o != card_io_space_o);
  endproperty
  a_card_upper: assert property (p_card_upper)
    else $error("wrong space for upper half");

  // Lower half uses the lower attribute bit
  property p_card_lower;
    card_req_i && !upper_address_line_i && chk_sel_card |=>
      (card_io_space_o == $past(chk_sel_lower));
  endproperty
  a_card_lower: assert property (p_card_lower)
    else $error("wrong space for lower half");

  // Non-card areas select no card space
  property p_card_type;
    card_req_i && !chk_sel_card |=> !card_io_space_o && !card_mem_space_o;
  endproperty
  a_card_type: assert property (p_card_type)
    else $error("attribute applied to non-card area");

  // Reserved bits read as zero
  property p_reserved_zero;
    wb_ack_o && !wb_we_i |->
      ((wb_adr_i[7:2] != SDSA_ADR_SDRAM[7:2]) || !wb_dat_o[SDSA_RSV_BIT]) &&
      (((wb_adr_i[7:2] != SDSA_ADR_CARD5[7:2]) && (wb_adr_i[7:2] != SDSA_ADR_CARD6[7:2])) ||
       ((wb_dat_o[31:22] == 10'h000) && (wb_dat_o[19:15] == 5'h00)));
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved bits read nonzero");

  // Main scenarios
  c_ref_then_act: cover property (cmd_valid_o && (cmd_o == SDSA_CMD_AUTO_REFRESH)
                                  ##[3:12] cmd_valid_o && (cmd_o == SDSA_CMD_ROW_ACTIVATE));
  c_wra_then_act: cover property (cmd_valid_o && (cmd_o == SDSA_CMD_WRITE_AUTOPRE)
                                  ##[2:6] cmd_valid_o && (cmd_o == SDSA_CMD_ROW_ACTIVATE));
  c_io_card:      cover property (card_valid_o && card_io_space_o);
endmodule
`default_nettype wire

// File: tb/sdsa_sdram_model.sv
// SDRAM-side model stamping the bus clock cycle of each arriving command.
// Assumes commands arrive as one-cycle issue pulses on the bus clock.
`timescale 1ns/10ps
`default_nettype none
module sdsa_sdram_model (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Command from the device
  input  wire logic cmd_valid_i,
  // Cycle of last command
  output int        stamp_o
);
  int cyc_ff;
  // Cycle count and stamp of the last issue
  always_ff @(posedge clk_i) begin
    cyc_ff <= rst_i ? 0 : cyc_ff + 1;
    if (cmd_valid_i) stamp_o <= cyc_ff;
  end
endmodule
`default_nettype wire

// File: tb/tb_top.sv
// Self-checking bench: registers, command spacing, card space decode.
// Assumes the design answers Wishbone and command handshakes.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import sdsa_pkg::*;
  typedef struct {
    logic [31:0] r0;
    logic [31:0] mode;
    sdsa_cmd_e   a;
    sdsa_cmd_e   b;
    int          gap;
  } sdsa_tb_row_s;
  logic        clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, req_valid_i;
  logic        req_ack_o, cmd_valid_o, card_req_i, card_area_sel_i, upper_address_line_i;
  logic        card_valid_o, card_io_space_o, card_mem_space_o;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic [1:0]  req_bank_i, cmd_bank_o;
  sdsa_cmd_e   req_cmd_i, cmd_o;
  int          n_errors, checks, stamp, t0, t1;
  sdsa_tb_row_s rows [8] = '{
    '{32'h0, 32'h0, SDSA_CMD_AUTO_REFRESH, SDSA_CMD_ROW_ACTIVATE, 3},
    '{32'h1, 32'h0, SDSA_CMD_AUTO_REFRESH, SDSA_CMD_AUTO_REFRESH, 4},
    '{32'h2, 32'h0, SDSA_CMD_AUTO_REFRESH, SDSA_CMD_MODE_SET, 6},
    '{32'h3, 32'h0, SDSA_CMD_AUTO_REFRESH, SDSA_CMD_ROW_ACTIVATE, 9},
    '{32'h3, 32'h0, SDSA_CMD_SELF_EXIT, SDSA_CMD_ROW_ACTIVATE, 9},
    '{32'h10, 32'h0, SDSA_CMD_WRITE_AUTOPRE, SDSA_CMD_ROW_ACTIVATE, 3},
    '{32'h18, 32'h0, SDSA_CMD_WRITE_AUTOPRE, SDSA_CMD_ROW_ACTIVATE, 4},
    '{32'h18, 32'h1, SDSA_CMD_PLAIN_WRITE, SDSA_CMD_PRECHARGE, 4}};
  sdsa_top sdsa_top_inst (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .req_valid_i, .req_cmd_i, .req_bank_i,
    .req_ack_o, .cmd_valid_o, .cmd_o, .cmd_bank_o, .card_req_i, .card_area_sel_i,
    .upper_address_line_i, .card_valid_o, .card_io_space_o, .card_mem_space_o);
  sdsa_sdram_model sdsa_sdram_model_inst (.clk_i, .rst_i, .cmd_valid_i(cmd_valid_o),
    .stamp_o(stamp));
  // Bus clock
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  task automatic conclude;
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One classic Wishbone cycle, read data into rd
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    i = 0;
    do begin @(posedge clk_i); i++; end while (wb_ack_o !== 1'b1 && i < 20);
    if (wb_ack_o !== 1'b1) begin n_errors++; conclude(); end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  // Command request held until acknowledged, t gets its issue cycle
  task automatic cmd(input sdsa_cmd_e c, output int t);
    int i;
    req_valid_i <= 1'b1;
    req_cmd_i <= c;
    req_bank_i <= 2'h1;
    i = 0;
    do begin @(posedge clk_i); i++; end while (req_ack_o !== 1'b1 && i < 40);
    if (req_ack_o !== 1'b1) begin n_errors++; conclude(); end
    req_valid_i <= 1'b0;
    @(posedge clk_i);
    t = stamp;
  endtask
  // One card access sample and its decoded space
  task automatic card(input logic s, input logic u, input logic io, input logic mem);
    @(posedge clk_i);
    card_req_i <= 1'b1;
    card_area_sel_i <= s;
    upper_address_line_i <= u;
    repeat (2) @(posedge clk_i);
    chk("card_valid", 32'h1, card_valid_o);
    chk("io", io, card_io_space_o);
    chk("mem", mem, card_mem_space_o);
  endtask
  // Main sequence
  initial begin
    {rst_i, wb_sel_i} = 5'h1F;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, req_valid_i, req_bank_i} = '0;
    {card_req_i, card_area_sel_i, upper_address_line_i} = 3'h0;
    req_cmd_i = SDSA_CMD_READ;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, 8'h00, 32'h0);
    chk("sdram_rst", 32'h0000_0500, rd);
    wb(1'b1, 8'h00, 32'hFFFF_FFFF);
    wb(1'b0, 8'h00, 32'h0);
    chk("sdram_rw", SDSA_SDRAM_WMASK, rd);
    wb(1'b1, 8'h04, 32'hFFFF_FFFF);
    wb(1'b0, 8'h04, 32'h0);
    chk("card5_rw", SDSA_CARD_WMASK, rd);
    wb(1'b0, 8'h14, 32'h0);
    chk("unmapped", 32'h0, rd);
    $display("test registers done");
    foreach (rows[k]) begin
      wb(1'b1, 8'h0C, rows[k].mode);
      wb(1'b1, 8'h00, rows[k].r0);
      cmd(rows[k].a, t0);
      cmd(rows[k].b, t1);
      chk("gap", rows[k].gap, t1 - t0);
    end
    $display("test spacing done");
    wb(1'b1, 8'h0C, 32'h6);
    wb(1'b1, 8'h04, 32'h0020_0000);
    wb(1'b1, 8'h08, 32'h0010_0000);
    for (int u = 0; u < 2; u++) begin
      card(1'b0, u[0], u[0], !u[0]);
      card(1'b1, u[0], !u[0], u[0]);
    end
    wb(1'b1, 8'h0C, 32'h0);
    card(1'b0, 1'b1, 1'b0, 1'b0);
    $display("test card done");
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, 8'h04, 32'h0);
    chk("card5_rst", 32'h0000_0500, rd);
    wb(1'b0, 8'h10, 32'h0);
    chk("status_idle", 32'h0, rd);
    $display("test reset done");
    conclude();
  end
endmodule
`default_nettype wire
